// File: scc_defines.svh
// Constants for the system clock, reset and power controller
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
`define SCC_CLK_MHZ 250
`define SCC_PLL_SETTLE_US 100
`define SCC_PLL_SETTLE_CYC (`SCC_PLL_SETTLE_US * `SCC_CLK_MHZ)
`define SCC_WAKE_CYC 2048
`define SCC_RST_FILT_NS 12
`define SCC_RST_FILT_CYC ((`SCC_RST_FILT_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_SWITCH_CYC 2
`define SCC_EXT_PINS 9
`define SCC_IRQ_LINES 4
`define SCC_PERIPHS 8
`define SCC_PCLK_QUARTER 2'h0
`define SCC_PCLK_FULL 2'h1
`define SCC_PCLK_HALF 2'h2
`define SCC_PLL_DIV_BASE 5'h02
`define SCC_RESET_VECTOR 32'h00000000
`endif

// File: scc_pkg.sv
// Types shared by the system clock, reset and power controller
package scc_pkg;
`include "scc_defines.svh"

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_WAKE = 3'h1,
    ST_INIT = 3'h2,
    ST_RUN = 3'h3,
    ST_IDLE = 3'h4,
    ST_PDOWN = 3'h5,
    ST_SWITCH = 3'h6
  } scc_state_e;

  typedef struct packed {
    logic pllEnable;
    logic pllConnect;
    logic [4:0] pllMultSel;
    logic [1:0] pllDivSel;
    logic [1:0] pclkRatio;
    logic idleReq;
    logic pdownReq;
    logic vectorSram;
    logic [`SCC_PERIPHS-1:0] periphOn;
    logic [`SCC_EXT_PINS-1:0] extEdge;
    logic [`SCC_EXT_PINS-1:0] extHigh;
    logic [2*`SCC_EXT_PINS-1:0] extRoute;
    logic [`SCC_EXT_PINS-1:0] extClear;
    logic [`SCC_IRQ_LINES-1:0] extWakeEn;
  } scc_ctrl_s;

  typedef struct packed {
    logic cpuClkEn;
    logic memClkEn;
    logic busClkEn;
    logic pclkEn;
    logic [`SCC_PERIPHS-1:0] periphClkEn;
  } scc_clken_s;

  typedef struct packed {
    logic pllPowerOn;
    logic [5:0] pllMult;
    logic [4:0] pllDivide;
    logic [9:0] ccoRatio;
    logic pllLocked;
    logic cpuSelPll;
  } scc_pll_s;
endpackage : scc_pkg

// File: scc_pin_sync.sv
// Three-stage pin synchroniser with stable level and edge pulses
`timescale 1ns/10ps
module scc_pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] resetLevel,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, rise_d, fall_q, fall_d;
  logic started_q;

  // A change counts only once stages two and three agree
  always_comb begin
    lvl_d = started_q ? ((s2_q == s3_q) ? s3_q : lvl_q) : resetLevel;
    rise_d = lvl_d & ~lvl_q & {W{started_q}};
    fall_d = ~lvl_d & lvl_q & {W{started_q}};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
      started_q <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      started_q <= 1'b1;
    end
  end

  assign level = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;
endmodule : scc_pin_sync

// File: scc_pclk_div.sv
// Peripheral clock enable divider: full, half or quarter rate
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_pclk_div
  import scc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] ratio,
  input wire logic run,
  output logic pclkEn
);
  logic [1:0] cnt_q, cnt_d;
  logic en_q, en_d, term;

  always_comb begin
    unique case (ratio)
      `SCC_PCLK_FULL: term = 1'b1;
      `SCC_PCLK_HALF: term = cnt_q[0];
      default: term = (cnt_q == 2'h3);
    endcase
    cnt_d = run ? 2'(cnt_q + 2'h1) : 2'h0;
    en_d = run & term;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      en_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  assign pclkEn = en_q;

  property p_quarterGap;
    @(posedge ref_clk) disable iff (!rst_n)
    (ratio == `SCC_PCLK_QUARTER && run && en_q) ##1 (run && ratio == `SCC_PCLK_QUARTER) |-> !en_q;
  endproperty
  a_quarterGap: assert property (p_quarterGap) else $error("quarter rate enable too dense");
endmodule : scc_pclk_div

// File: scc_sys_ctrl.sv
// System clock, reset, wake-up and power-mode controller
// What this block does
// - CPU clock is the oscillator unless PLL is running, locked and connected.
// - PLL multiplier accepts every integer one to thirty-two.
// - PLL output divider is two, four, eight or sixteen only.
// - After any chip reset the PLL is off and bypassed.
// - Lock is never shown before the settling interval after enabling.
// - Reset pin or watchdog timeout raise chip reset and start wake-up timer.
// - Reset pin passes a glitch filter; short pulses are ignored.
// - Internal reset holds until pin released, oscillator counted, init done.
// - On release the processor fetches from vector address zero.
// - Every power-down exit runs the wake-up timer first.
// - Nine interrupt pins, edge or level, route onto four request lines.
// - Enabled interrupt pins wake from power-down with no clock running.
// - Mapping control picks first external bank or on-chip RAM for vectors.
// - Idle halts execution until reset or interrupt; peripherals keep clocking.
// - Idle stops processor, memory and internal bus clocks.
// - Power-down stops oscillator and all clocks while state is kept.
// - Power-down ends only on reset or a clockless interrupt.
// - Each peripheral clock can be stopped individually.
// - Peripheral clock runs at full, half or quarter rate; quarter after reset.
// - PLL keeps running through idle if it was running.
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_sys_ctrl
  import scc_pkg::*;
#(
  parameter logic [14:0] PLL_SETTLE_CYC = 15'(`SCC_PLL_SETTLE_CYC),
  parameter logic [11:0] WAKE_CYC = 12'(`SCC_WAKE_CYC)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic extResetPinN,
  input wire logic watchdogTimeout,
  input wire logic oscGood,
  input wire logic initDone,
  input wire logic periphIrq,
  input wire scc_pkg::scc_ctrl_s ctrl,
  input wire logic [`SCC_EXT_PINS-1:0] extIrqPins,
  output logic oscEnable,
  output logic sysResetN,
  output logic [31:0] resetVector,
  output logic vectorFromSram,
  output logic wdResetFlag,
  output logic [`SCC_IRQ_LINES-1:0] irqLines,
  output scc_pkg::scc_pll_s pll,
  output scc_pkg::scc_clken_s clken
);
  import scc_pkg::*;

  localparam logic [3:0] FILT_CYC = 4'(`SCC_RST_FILT_CYC);
  localparam logic [1:0] SWITCH_CYC = 2'(`SCC_SWITCH_CYC);

  function automatic logic [`SCC_IRQ_LINES-1:0] routeLines(input logic [`SCC_EXT_PINS-1:0] act,
                                                           input logic [2*`SCC_EXT_PINS-1:0] route);
    logic [`SCC_IRQ_LINES-1:0] r;
    r = '0;
    for (int i = 0; i < `SCC_EXT_PINS; i++) begin
      r[route[2*i+:2]] = r[route[2*i+:2]] | act[i];
    end
    return r;
  endfunction : routeLines

  function automatic logic [9:0] ccoRatio(input logic [5:0] mult, input logic [4:0] div);
    return 10'(mult) * 10'(div);
  endfunction : ccoRatio

  scc_state_e state_q, state_d;
  logic [11:0] wakeCnt_q, wakeCnt_d;
  logic [1:0] swCnt_q, swCnt_d;
  logic fromPd_q, fromPd_d, cpuSel_q, cpuSel_d;
  logic [3:0] filtCnt_q, filtCnt_d;
  logic rstFilt_q, rstFilt_d, wdFlag_q, wdFlag_d;
  logic pllOn_q, pllOn_d, lock_q, lock_d;
  logic [14:0] lockCnt_q, lockCnt_d;
  logic [4:0] multSel_q, multSel_d;
  logic [1:0] divSel_q, divSel_d, ratio_q, ratio_d;
  logic vecSram_q, vecSram_d, sysRstN_q, sysRstN_d;
  logic [`SCC_PERIPHS-1:0] periphOn_q, periphOn_d;
  logic [`SCC_EXT_PINS-1:0] pend_q, pend_d, pinAct;
  logic [`SCC_IRQ_LINES-1:0] lines_q, lines_d;
  logic [`SCC_EXT_PINS-1:0] extLvl, extRise, extFall;
  logic rstPinLvl, chipRst, oscOk, connWant, switchNeed, irqAny, irqWake, asyncWake, pclkEn;
  logic [5:0] multVal;
  logic [4:0] divVal;

  scc_pin_sync #(.W(1)) u_rstSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(extResetPinN),
    .resetLevel(1'b1),
    .level(rstPinLvl),
    .rise(),
    .fall()
  );

  scc_pin_sync #(.W(1)) u_oscSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(oscGood),
    .resetLevel(1'b0),
    .level(oscOk),
    .rise(),
    .fall()
  );

  scc_pin_sync #(.W(`SCC_EXT_PINS)) u_extSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(extIrqPins),
    .resetLevel('0),
    .level(extLvl),
    .rise(extRise),
    .fall(extFall)
  );

  // Reset pin filter: low must persist FILT_CYC cycles before it counts
  always_comb begin
    filtCnt_d = rstPinLvl ? 4'h0 : ((filtCnt_q == FILT_CYC) ? filtCnt_q : 4'(filtCnt_q + 4'h1));
    rstFilt_d = !rstPinLvl && (rstFilt_q || filtCnt_q == FILT_CYC - 4'h1);
    chipRst = rstFilt_q | watchdogTimeout;
    // Watchdog event wins over the clear by a pin reset
    wdFlag_d = watchdogTimeout | (wdFlag_q & ~rstFilt_q);
  end

  // External interrupt pins: edges latch, levels pass straight through
  always_comb begin
    pend_d = ((extRise & ctrl.extHigh) | (extFall & ~ctrl.extHigh)) & ctrl.extEdge;
    pend_d = pend_d | (pend_q & ~ctrl.extClear);
    pinAct = (ctrl.extEdge & pend_q) | (~ctrl.extEdge & ~(extLvl ^ ctrl.extHigh));
    lines_d = routeLines(pinAct, ctrl.extRoute);
    irqAny = (|lines_q) | periphIrq;
    irqWake = |(lines_q & ctrl.extWakeEn);
    // Raw pins, no clock involved: this path restarts the oscillator
    asyncWake = |(routeLines(~(extIrqPins ^ ctrl.extHigh), ctrl.extRoute) & ctrl.extWakeEn);
  end

  assign oscEnable = (state_q != ST_PDOWN) | asyncWake | ~extResetPinN;

  // Switch to the PLL only once it is on and locked
  assign connWant = ctrl.pllConnect & pllOn_q & lock_q & ~ctrl.pdownReq;
  assign switchNeed = connWant != cpuSel_q;

  always_comb begin
    state_d = state_q;
    wakeCnt_d = wakeCnt_q;
    swCnt_d = swCnt_q;
    fromPd_d = fromPd_q;
    cpuSel_d = cpuSel_q;
    unique case (state_q)
      ST_RESET: begin
        fromPd_d = 1'b0;
        cpuSel_d = 1'b0;
        wakeCnt_d = 12'h000;
        if (!chipRst) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (oscOk) begin
          if (wakeCnt_q == WAKE_CYC - 12'h001) begin
            state_d = fromPd_q ? ST_RUN : ST_INIT;
            wakeCnt_d = 12'h000;
          end else begin
            wakeCnt_d = 12'(wakeCnt_q + 12'h001);
          end
        end
      end
      ST_INIT: begin
        if (initDone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (switchNeed) begin
          state_d = ST_SWITCH;
          swCnt_d = 2'h0;
        end else if (ctrl.pdownReq) begin
          state_d = ST_PDOWN;
        end else if (ctrl.idleReq) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irqAny) begin
          state_d = ST_RUN;
        end
      end
      ST_PDOWN: begin
        fromPd_d = 1'b1;
        wakeCnt_d = 12'h000;
        if (irqWake) begin
          state_d = ST_WAKE;
        end
      end
      ST_SWITCH: begin
        // Gate the CPU clock on both sides of the source change
        if (swCnt_q == SWITCH_CYC - 2'h1) begin
          cpuSel_d = connWant;
        end
        if (swCnt_q == SWITCH_CYC) begin
          state_d = ST_RUN;
        end else begin
          swCnt_d = 2'(swCnt_q + 2'h1);
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (chipRst) begin
      state_d = ST_RESET;
      // Drop the PLL selection together with the PLL, while the CPU clock is gated
      cpuSel_d = 1'b0;
    end
  end

  // PLL power, settings and lock; settings freeze while it runs
  always_comb begin
    unique case (state_q)
      ST_RUN, ST_SWITCH: pllOn_d = ctrl.pllEnable | cpuSel_q;
      ST_IDLE: pllOn_d = pllOn_q;
      default: pllOn_d = 1'b0;
    endcase
    if (chipRst) begin
      pllOn_d = 1'b0;
    end
    multSel_d = pllOn_q ? multSel_q : ctrl.pllMultSel;
    divSel_d = pllOn_q ? divSel_q : ctrl.pllDivSel;
    lockCnt_d = !pllOn_q ? 15'h0000 : ((lockCnt_q == PLL_SETTLE_CYC) ? lockCnt_q : 15'(lockCnt_q + 15'h0001));
    lock_d = pllOn_q && pllOn_d && lockCnt_q == PLL_SETTLE_CYC;
    multVal = 6'({1'b0, multSel_q}) + 6'h01;
    divVal = `SCC_PLL_DIV_BASE << divSel_q;
  end

  // Software-facing settings return to defaults on chip reset
  always_comb begin
    ratio_d = ratio_q;
    vecSram_d = vecSram_q;
    periphOn_d = periphOn_q;
    if (state_q == ST_RESET) begin
      ratio_d = `SCC_PCLK_QUARTER;
      vecSram_d = 1'b0;
      periphOn_d = '0;
    end else if (state_q == ST_RUN || state_q == ST_INIT) begin
      ratio_d = (ctrl.pclkRatio == 2'h3) ? `SCC_PCLK_QUARTER : ctrl.pclkRatio;
      vecSram_d = ctrl.vectorSram;
      periphOn_d = ctrl.periphOn;
    end
    sysRstN_d = (state_d != ST_RESET) && !(state_d == ST_WAKE && !fromPd_d) && (state_d != ST_INIT);
  end

  scc_pclk_div u_pclkDiv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ratio(ratio_q),
    .run(state_q == ST_RUN || state_q == ST_IDLE || state_q == ST_SWITCH || state_q == ST_INIT),
    .pclkEn(pclkEn)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      wakeCnt_q <= 12'h000;
      swCnt_q <= 2'h0;
      fromPd_q <= 1'b0;
      cpuSel_q <= 1'b0;
      filtCnt_q <= 4'h0;
      rstFilt_q <= 1'b0;
      wdFlag_q <= 1'b0;
      pllOn_q <= 1'b0;
      lock_q <= 1'b0;
      lockCnt_q <= 15'h0000;
      multSel_q <= 5'h00;
      divSel_q <= 2'h0;
      ratio_q <= `SCC_PCLK_QUARTER;
      vecSram_q <= 1'b0;
      periphOn_q <= '0;
      pend_q <= '0;
      lines_q <= '0;
      sysRstN_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wakeCnt_q <= wakeCnt_d;
      swCnt_q <= swCnt_d;
      fromPd_q <= fromPd_d;
      cpuSel_q <= cpuSel_d;
      filtCnt_q <= filtCnt_d;
      rstFilt_q <= rstFilt_d;
      wdFlag_q <= wdFlag_d;
      pllOn_q <= pllOn_d;
      lock_q <= lock_d;
      lockCnt_q <= lockCnt_d;
      multSel_q <= multSel_d;
      divSel_q <= divSel_d;
      ratio_q <= ratio_d;
      vecSram_q <= vecSram_d;
      periphOn_q <= periphOn_d;
      pend_q <= pend_d;
      lines_q <= lines_d;
      sysRstN_q <= sysRstN_d;
    end
  end

  // CPU, memory and bus clocks only in run; peripherals keep pclk in idle
  assign clken.cpuClkEn = (state_q == ST_RUN) & ~chipRst;
  assign clken.memClkEn = (state_q == ST_RUN);
  assign clken.busClkEn = (state_q == ST_RUN);
  assign clken.pclkEn = pclkEn;
  assign clken.periphClkEn = periphOn_q & {`SCC_PERIPHS{pclkEn}};
  assign pll.pllPowerOn = pllOn_q;
  assign pll.pllMult = multVal;
  assign pll.pllDivide = divVal;
  assign pll.ccoRatio = ccoRatio(multVal, divVal);
  assign pll.pllLocked = lock_q;
  assign pll.cpuSelPll = cpuSel_q;
  assign sysResetN = sysRstN_q;
  assign resetVector = `SCC_RESET_VECTOR;
  assign vectorFromSram = vecSram_q;
  assign wdResetFlag = wdFlag_q;
  assign irqLines = lines_q;

  logic [15:0] onCnt_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      onCnt_q <= 16'h0000;
    end else begin
      onCnt_q <= !pllOn_q ? 16'h0000 : ((&onCnt_q) ? onCnt_q : 16'(onCnt_q + 16'h0001));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pdExit;
    state_q == ST_PDOWN ##1 state_q != ST_PDOWN;
  endsequence
  sequence s_gatedPair;
    !clken.cpuClkEn ##1 !clken.cpuClkEn;
  endsequence

  property p_oscWhenNoPll;
    !(pllOn_q && lock_q) |-> !cpuSel_q;
  endproperty
  a_oscWhenNoPll: assert property (p_oscWhenNoPll) else $error("cpu on pll while pll not ready");
  property p_multRange;
    pll.pllMult >= 6'h01 && pll.pllMult <= 6'h20 && pll.ccoRatio == 10'(pll.pllMult) * 10'(pll.pllDivide);
  endproperty
  a_multRange: assert property (p_multRange) else $error("pll multiplier out of range");
  property p_divLegal;
    pll.pllDivide inside {5'h02, 5'h04, 5'h08, 5'h10};
  endproperty
  a_divLegal: assert property (p_divLegal) else $error("illegal pll divider");
  property p_resetBypass;
    state_q == ST_RESET |=> !cpuSel_q && !pllOn_q;
  endproperty
  a_resetBypass: assert property (p_resetBypass) else $error("pll not bypassed after reset");
  property p_lockLate;
    lock_q |-> onCnt_q > 16'(PLL_SETTLE_CYC);
  endproperty
  a_lockLate: assert property (p_lockLate) else $error("lock before settling time");
  property p_wdReset;
    watchdogTimeout |=> state_q == ST_RESET ##1 !sysRstN_q;
  endproperty
  a_wdReset: assert property (p_wdReset) else $error("watchdog did not reset");
  property p_filter;
    $rose(rstFilt_q) |-> $past(filtCnt_q) == FILT_CYC - 4'h1 && !$past(rstPinLvl, 2);
  endproperty
  a_filter: assert property (p_filter) else $error("reset filter passed short pulse");
  property p_releaseAfterInit;
    $rose(sysRstN_q) |-> $past(state_q) == ST_INIT && $past(initDone);
  endproperty
  a_releaseAfterInit: assert property (p_releaseAfterInit) else $error("reset released early");
  property p_pdWake;
    s_pdExit |-> state_q == ST_WAKE || state_q == ST_RESET;
  endproperty
  a_pdWake: assert property (p_pdWake) else $error("power-down exit skipped wake timer");
  property p_idleGate;
    state_q == ST_IDLE |-> !clken.cpuClkEn && !clken.memClkEn && !clken.busClkEn;
  endproperty
  a_idleGate: assert property (p_idleGate) else $error("cpu clock running in idle");
  property p_glitchFree;
    $changed(cpuSel_q) |-> !clken.cpuClkEn && !$past(clken.cpuClkEn);
  endproperty
  a_glitchFree: assert property (p_glitchFree) else $error("clock source switched while running");
  property p_switchGate;
    state_q == ST_RUN && switchNeed |=> s_gatedPair;
  endproperty
  a_switchGate: assert property (p_switchGate) else $error("cpu clock not gated around switch");
endmodule : scc_sys_ctrl

// File: scc_core_model.sv
// Core-side partner: oscillator amplitude and on-chip init model
`timescale 1ns/10ps
module scc_core_model
  import scc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sysResetN,
  input wire logic oscEnable,
  output logic oscGood,
  output logic initDone
);
  logic [2:0] initCnt;
  initial begin
    initCnt = 3'h0;
  end
  // Amplitude needs time after a restart, so good lags enable; a level wait cannot miss time zero
  always begin
    oscGood = 1'b0;
    wait (oscEnable === 1'b1);
    #10;
    oscGood = (oscEnable === 1'b1);
    wait (oscEnable !== 1'b1);
  end
  // Init logic finishes a few cycles into each internal reset
  always @(posedge ref_clk) begin
    if (sysResetN === 1'b1) begin
      initCnt <= 3'h0;
    end else if (initCnt != 3'h7) begin
      initCnt <= initCnt + 3'h1;
    end
  end
  assign initDone = (initCnt >= 3'h4);
endmodule : scc_core_model

// File: tb.sv
// Self-checking testbench for the system clock, reset and power controller
`timescale 1ns/10ps
module tb;
  import scc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n, extResetPinN, watchdogTimeout, periphIrq, oscGood, initDone;
  logic oscEnable, sysResetN, vectorFromSram, wdResetFlag;
  logic [31:0] resetVector;
  logic [8:0] extIrqPins;
  logic [3:0] irqLines;
  scc_ctrl_s ctrl;
  scc_pll_s pll;
  scc_clken_s clken;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  // Clock stops low in power-down, as the real oscillator would
  always #2 ref_clk = (oscEnable !== 1'b0) ? ~ref_clk : 1'b0;

  scc_sys_ctrl #(.PLL_SETTLE_CYC(15'h0014), .WAKE_CYC(12'h008)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .extResetPinN(extResetPinN), .watchdogTimeout(watchdogTimeout),
    .oscGood(oscGood), .initDone(initDone), .periphIrq(periphIrq), .ctrl(ctrl), .extIrqPins(extIrqPins),
    .oscEnable(oscEnable), .sysResetN(sysResetN), .resetVector(resetVector), .vectorFromSram(vectorFromSram),
    .wdResetFlag(wdResetFlag), .irqLines(irqLines), .pll(pll), .clken(clken));

  scc_core_model partner (.ref_clk(ref_clk), .sysResetN(sysResetN), .oscEnable(oscEnable),
    .oscGood(oscGood), .initDone(initDone));

  task finish_test;
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step

  task t_boot;
    n = 0;
    while (sysResetN !== 1'b1 && n < 200) begin step(1); n++; end
    chk(n >= 8, 1, "reset released before wake count");
    chk(sysResetN, 1, "internal reset stuck");
    chk(resetVector, 32'h00000000, "reset vector");
    chk({pll.pllPowerOn, pll.cpuSelPll}, 0, "pll not off and bypassed");
  endtask : t_boot

  task pclk_count(input logic [1:0] r, input int exp);
    ctrl.pclkRatio = r;
    step(3);
    n = 0;
    repeat (16) begin step(1); n += (clken.pclkEn === 1'b1); end
    chk(n, exp, "peripheral clock rate");
  endtask : pclk_count

  task t_pclk;
    ctrl.periphOn = 8'hA5;
    pclk_count(2'h0, 4);
    pclk_count(2'h2, 8);
    pclk_count(2'h3, 4);
    pclk_count(2'h1, 16);
    chk(clken.periphClkEn, 32'h000000A5, "peripheral gating");
    ctrl.periphOn = 8'h5A;
    step(3);
    chk(clken.periphClkEn, 32'h0000005A, "peripheral gating");
    ctrl.vectorSram = 1'b1;
    step(2);
    chk(vectorFromSram, 1, "vectors not in sram");
    ctrl.vectorSram = 1'b0;
    step(2);
    chk(vectorFromSram, 0, "vectors not in first bank");
  endtask : t_pclk

  task t_pll;
    for (int i = 0; i < 4; i++) begin
      ctrl.pllDivSel = 2'(i);
      step(2);
      chk(pll.pllDivide, 32'h2 << i, "output divider");
    end
    ctrl.pllMultSel = 5'h1F;
    step(2);
    chk(pll.pllMult, 32'h20, "multiplier top");
    ctrl.pllMultSel = 5'h00;
    step(2);
    chk(pll.pllMult, 32'h1, "multiplier bottom");
    // Five times eight keeps the oscillator stage inside its band
    ctrl.pllMultSel = 5'h04;
    ctrl.pllDivSel = 2'h2;
    step(2);
    chk(pll.ccoRatio, 32'h28, "oscillator stage ratio");
    ctrl.pllEnable = 1'b1;
    n = 0;
    while (pll.pllLocked !== 1'b1 && n < 100) begin step(1); n++; end
    chk(n >= 20 && n < 100, 1, "lock timing");
    ctrl.pllConnect = 1'b1;
    n = 0;
    while (pll.cpuSelPll !== 1'b1 && n < 10) begin step(1); n++; end
    chk(clken.cpuClkEn, 0, "source switched while clock running");
    step(2);
    chk({clken.cpuClkEn, pll.cpuSelPll}, 32'h3, "pll not driving cpu");
  endtask : t_pll

  task t_irq;
    ctrl.extRoute[7:6] = 2'h2;
    ctrl.extHigh[3] = 1'b1;
    ctrl.extRoute[11:10] = 2'h1;
    ctrl.extEdge[5] = 1'b1;
    ctrl.extHigh[5] = 1'b1;
    extIrqPins[5] = 1'b1;
    step(2);
    extIrqPins[5] = 1'b0;
    step(8);
    chk(irqLines, 32'h2, "edge not latched on its line");
    ctrl.extClear[5] = 1'b1;
    step(2);
    ctrl.extClear[5] = 1'b0;
    step(3);
    chk(irqLines, 32'h0, "edge pending not cleared");
    ctrl.idleReq = 1'b1;
    step(2);
    ctrl.idleReq = 1'b0;
    chk({clken.cpuClkEn, clken.memClkEn, clken.busClkEn}, 0, "idle clocks running");
    chk(pll.pllPowerOn, 1, "pll stopped in idle");
    n = 0;
    repeat (10) begin step(1); n += (clken.pclkEn === 1'b1); end
    chk(n, 10, "peripheral clock stopped in idle");
    chk(clken.cpuClkEn, 0, "idle left without event");
    extIrqPins[3] = 1'b1;
    n = 0;
    while (clken.cpuClkEn !== 1'b1 && n < 20) begin step(1); n++; end
    chk({irqLines, clken.cpuClkEn}, 32'h9, "level pin did not wake idle");
    extIrqPins[3] = 1'b0;
    step(8);
    ctrl.idleReq = 1'b1;
    step(2);
    ctrl.idleReq = 1'b0;
    chk(clken.cpuClkEn, 0, "idle not entered");
    periphIrq = 1'b1;
    step(2);
    periphIrq = 1'b0;
    chk(clken.cpuClkEn, 1, "peripheral interrupt did not wake idle");
  endtask : t_irq

  task t_resets;
    ctrl.pllEnable = 1'b0;
    ctrl.pllConnect = 1'b0;
    watchdogTimeout = 1'b1;
    step(1);
    watchdogTimeout = 1'b0;
    step(1);
    chk(sysResetN, 0, "watchdog gave no reset");
    chk({pll.pllPowerOn, pll.cpuSelPll}, 0, "pll alive in reset");
    t_boot();
    chk(wdResetFlag, 1, "watchdog flag");
    extResetPinN = 1'b0;
    step(1);
    extResetPinN = 1'b1;
    n = 0;
    repeat (20) begin step(1); n += (sysResetN !== 1'b1); end
    chk(n, 0, "glitch caused reset");
    extResetPinN = 1'b0;
    step(20);
    chk(sysResetN, 0, "reset released while pin low");
    extResetPinN = 1'b1;
    t_boot();
    chk(wdResetFlag, 0, "pin reset kept watchdog flag");
  endtask : t_resets

  task t_pdown;
    ctrl.extWakeEn = 4'h4;
    ctrl.pdownReq = 1'b1;
    @(posedge ref_clk);
    #1;
    ctrl.pdownReq = 1'b0;
    #40;
    chk({oscEnable, pll.pllPowerOn, sysResetN}, 32'h1, "power-down state");
    extIrqPins[5] = 1'b1;
    #20;
    chk(oscEnable, 0, "woken by a line without wake enable");
    extIrqPins[5] = 1'b0;
    extIrqPins[3] = 1'b1;
    #1;
    chk(oscEnable, 1, "pin did not restart oscillator");
    n = 0;
    while (clken.cpuClkEn !== 1'b1 && n < 60) begin step(1); n++; end
    chk(n >= 8 && n < 60, 1, "wake timer skipped");
    chk(sysResetN, 1, "power-down lost state");
  endtask : t_pdown

  // Counts periods by time, so a clock stopped in power-down cannot hang the run
  always #4 begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    extResetPinN = 1'b1;
    watchdogTimeout = 1'b0;
    periphIrq = 1'b0;
    extIrqPins = 9'h000;
    ctrl = '0;
    // Pins idle low, so all of them are taken as active high
    ctrl.extHigh = 9'h1FF;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_boot();
    t_pclk();
    t_pll();
    t_irq();
    t_resets();
    t_pdown();
    finish_test();
  end
endmodule : tb
